// *** dv/sas_sar_model.sv ***
`timescale 1ns/1ps
module sas_sar_model
    import sas_pkg::*;
(
    // Clock
    input  wire logic              clk,
    // Converter core side
    input  wire logic [CHAN_W-1:0] muxChannel,
    input  wire logic [REF_W-1:0]  refSelect,
    input  wire logic              sampleHold,
    input  wire logic              convActive,
    output logic      [RES_W-1:0]  sarData
);
    logic [RES_W-1:0] held = '0;

    // Capacitor keeps what was seen at the sample instant
    always @(posedge clk) begin
        if (sampleHold === 1'b1)
            held <= {refSelect, 2'b00, muxChannel} ^ 10'h155;
    end
    // Outside a conversion the comparator output is junk
    assign sarData = (convActive === 1'b1) ? held : ~held;
endmodule // sas_sar_model

// *** dv/tb_sas_sequencer.sv ***
`timescale 1ns/1ps
module tb_sas_sequencer;
    import sas_pkg::*;
    logic              clk, sys_rst, cyc, stb, we, ack, halted, quiet, powered, sh, active, irq;
    logic [3:0]        adr, sel;
    logic [31:0]       dat, rdat, rd;
    logic [6:0]        trig;
    logic [RES_W-1:0]  sarData;
    logic [CHAN_W-1:0] chan, ch1, ch2, ch3;
    logic [REF_W-1:0]  refs, rf;
    int                failCount = 0, testsRun = 0, nConv = 0, cnt = 0, n0;
    int                durQ[$], offQ[$], chQ[$];
    integer            seed = 32'h1e5a4be7;

    sas_sequencer sas_sequencer_inst (
        .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .trigSrc(trig),
        .cpuHalted(halted), .sleepQuietMode(quiet), .sarData(sarData), .adcPowered(powered),
        .muxChannel(chan), .refSelect(refs), .sampleHold(sh), .convActive(active), .convDoneIrq(irq));
    sas_sar_model sas_sar_model_inst (
        .clk(clk), .muxChannel(chan), .refSelect(refs), .sampleHold(sh), .convActive(active),
        .sarData(sarData));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----
    // Conversion monitor: offsets and lengths in clocks
    // ----
    always @(posedge clk) begin
        cnt <= (active === 1'b1) ? cnt + 1 : 0;
        if (sh === 1'b1) begin
            offQ.push_back(cnt);
            chQ.push_back(chan);
            nConv <= nConv + 1;
        end
        if (active !== 1'b1 && cnt != 0)
            durQ.push_back(cnt);
    end

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        testsRun++;
        if (s !== e) begin
            failCount++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Waits for ack with no limit of its own; the watchdog ends a hang
    task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task automatic waitConv();
        while (active !== 1'b1) @(posedge clk);
        while (active === 1'b1) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask

    task automatic waitN(input int k);
        while (nConv < k) @(posedge clk);
    endtask

    task automatic timing(input int s, input int e, input int hp);
        chk("sample offset", offQ.pop_front(), s * hp);
        chk("conversion length", durQ.pop_front(), e * hp);
    endtask

    function automatic logic [31:0] expRes(input logic [CHAN_W-1:0] c, input logic [REF_W-1:0] r);
        return {22'h0, {r, 2'b00, c} ^ 10'h155};
    endfunction

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", testsRun, failCount);
        if (failCount == 0 && testsRun > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        failCount++;
        summarize();
    end

    initial begin
        sys_rst = 1'b1; cyc = 0; stb = 0; we = 0; adr = 0; sel = 0; dat = 0; trig = 0; halted = 0; quiet = 0;
        // Three distinct channels, the first never zero
        ch1 = 6'($random(seed)) | 6'h01;
        ch2 = ~ch1;
        ch3 = ch1 ^ 6'h2a;
        rf  = 2'($random(seed));
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        // Read-only and unmapped places ignore writes
        wb(ADDR_RESULT, 1'b1, 32'h3ff);
        wb(4'h2, 1'b1, 32'hff);
        for (int a = 0; a < 16; a += 2) begin
            wb(4'(a), 1'b0, 32'h0);
            chk("reset read", rd, RESET_WORD);
        end
        wb(ADDR_INSEL, 1'b1, {24'h0, rf, ch1});
        repeat (3) @(posedge clk);
        chk("select while off", chan, 6'h00);
        wb(ADDR_CTRL_A, 1'b1, 32'h80);
        repeat (3) @(posedge clk);
        chk("select when on", {refs, chan}, {rf, ch1});
        // First conversion, then a normal one with a mid-run reselect
        durQ.delete(); offQ.delete();
        wb(ADDR_CTRL_A, 1'b1, 32'hc0);
        wb(ADDR_CTRL_A, 1'b0, 32'h0);
        chk("start while busy", rd[7:0], 8'hc0);
        waitConv();
        timing(29, 50, 1);
        wb(ADDR_RESULT, 1'b0, 32'h0);
        chk("first result", rd, expRes(ch1, rf));
        wb(ADDR_CTRL_A, 1'b0, 32'h0);
        chk("done state", rd[7:0], 8'h90);
        wb(ADDR_CTRL_A, 1'b1, 32'hd0);
        repeat (10) @(posedge clk);
        wb(ADDR_INSEL, 1'b1, {24'h0, rf, ch2});
        chk("locked select", chan, ch1);
        waitConv();
        timing(3, 26, 1);
        wb(ADDR_RESULT, 1'b0, 32'h0);
        chk("old channel result", rd, expRes(ch1, rf));
        chk("select resumed", chan, ch2);
        // Free running on own done flag
        wb(ADDR_CTRL_B, 1'b1, 32'h0);
        chQ.delete();
        n0 = nConv;
        wb(ADDR_CTRL_A, 1'b1, 32'he0);
        waitN(n0 + 2);
        wb(ADDR_INSEL, 1'b1, {24'h0, rf, ch3});
        waitN(n0 + 4);
        wb(ADDR_CTRL_A, 1'b0, 32'h0);
        chk("start held in free run", rd[6], 1'b1);
        wb(ADDR_CTRL_A, 1'b1, 32'h80);
        waitConv();
        chk("free ch0", chQ[0], ch2);
        chk("free ch1", chQ[1], ch2);
        chk("free ch2", chQ[2], ch3);
        chk("free ch3", chQ[3], ch3);
        // Every trigger source, with a held level and a busy-time edge
        for (int s = 1; s < 8; s++) begin
            wb(ADDR_CTRL_B, 1'b1, s);
            wb(ADDR_CTRL_A, 1'b1, 32'hb0);
            durQ.delete(); offQ.delete();
            n0 = nConv;
            trig[s-1] <= 1'b1;
            repeat (12) @(posedge clk);
            trig[s-1] <= 1'b0;
            repeat (2) @(posedge clk);
            trig[s-1] <= 1'b1;
            waitConv();
            repeat (20) @(posedge clk);
            chk("trigger count", nConv, n0 + 1);
            timing(4, 27, 1);
            trig[s-1] <= 1'b0;
        end
        // Software start with auto-trigger on
        wb(ADDR_CTRL_B, 1'b1, 32'h7);
        durQ.delete(); offQ.delete();
        n0 = nConv;
        wb(ADDR_CTRL_A, 1'b1, 32'he0);
        waitConv();
        chk("start under auto", nConv, n0 + 1);
        timing(3, 26, 1);
        // Sleep start
        wb(ADDR_CTRL_A, 1'b1, 32'h98);
        n0 = nConv;
        quiet <= 1'b1;
        halted <= 1'b1;
        waitConv();
        chk("sleep conversion", nConv, n0 + 1);
        chk("wake request", irq, 1'b1);
        halted <= 1'b0;
        quiet <= 1'b0;
        // Power cycle, slower divider
        wb(ADDR_CTRL_A, 1'b1, 32'h00);
        @(posedge clk);
        chk("powered off", powered, 1'b0);
        durQ.delete(); offQ.delete();
        wb(ADDR_CTRL_A, 1'b1, 32'hc1);
        waitConv();
        timing(29, 50, 2);
        wb(ADDR_RESULT, 1'b0, 32'h0);
        chk("divided result", rd, expRes(ch3, rf));
        summarize();
    end
endmodule // tb_sas_sequencer

// *** src/sas_pkg.sv ***
// Overview of operation
// RULE1 - Writing start while idle begins one conversion
// RULE2 - Start bit set until conversion completes
// RULE3 - Channel change waits for current conversion end
// RULE4 - Auto-trigger rising edge resets prescaler, starts conversion
// RULE5 - Held trigger or busy-time edges start nothing
// RULE6 - Trigger flag must be cleared between events
// RULE7 - Own done flag trigger free-runs regardless of clearing
// RULE8 - Start bit reads busy; write starts despite auto
// RULE9 - Prescaler runs while enabled, held reset otherwise
// RULE10 - Software keeps converter clock within resolution limits
// RULE11 - Software start begins at next converter rising edge
// RULE12 - Normal conversion 13 cycles, first one 25
// RULE13 - Sample-hold at 1.5 or 14.5 cycles
// RULE14 - Completion stores result, sets flag, clears start
// RULE15 - Triggered: sample at 2 cycles, plus 3 sync
// RULE16 - Free running restarts at once, start stays set
// RULE17 - Selections buffered, locked during conversion, unlocked last cycle
// RULE18 - Software waits one converter cycle before reselecting
// RULE19 - Software changes selection only at safe times
// RULE20 - Free-run channel change affects only later conversions
// RULE21 - Software discards first result after reference switch
// RULE22 - Sleep with irq enabled starts conversion on halt
// RULE23 - Enable powers converter, selections apply only enabled
// RULE24 - Divider field encoding chosen here: ratio two^(sel+1)
package sas_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_CTRL_A = 4'h0;
    localparam logic [3:0] ADDR_CTRL_B = 4'h4;
    localparam logic [3:0] ADDR_INSEL  = 4'h8;
    localparam logic [3:0] ADDR_RESULT = 4'hc;

    // Control/status A fields
    localparam int BIT_ENABLE  = 7;
    localparam int BIT_START   = 6;
    localparam int BIT_AUTO    = 5;
    localparam int BIT_DONE    = 4;
    localparam int BIT_IRQ_EN  = 3;
    localparam int DIV_LSB     = 0;
    localparam int DIV_W       = 3;
    // Control/status B fields
    localparam int TRIG_LSB    = 0;
    localparam int TRIG_W      = 3;
    // Input select fields
    localparam int CHAN_LSB    = 0;
    localparam int CHAN_W      = 6;
    localparam int REF_LSB     = 6;
    localparam int REF_W       = 2;

    localparam int RES_W       = 10;
    localparam int PRE_W       = 7;
    localparam int HALF_W      = 6;

    localparam logic [2:0]  TRIG_FREE_RUN  = 3'h0;
    localparam logic [1:0]  SYNC_CYCLES    = 2'h3;
    localparam logic [31:0] RESET_WORD     = 32'h0;

    // ----------------------------------------------------------------
    // Conversion timing in converter half cycles
    // ----------------------------------------------------------------
    localparam logic [HALF_W-1:0] HALF_SH_NORMAL  = 6'h03;
    localparam logic [HALF_W-1:0] HALF_END_NORMAL = 6'h1a;
    localparam logic [HALF_W-1:0] HALF_SH_FIRST   = 6'h1d;
    localparam logic [HALF_W-1:0] HALF_END_FIRST  = 6'h32;
    localparam logic [HALF_W-1:0] HALF_SH_TRIG    = 6'h04;
    localparam logic [HALF_W-1:0] HALF_END_TRIG   = 6'h1b;
    localparam logic [HALF_W-1:0] HALF_ONE        = 6'h01;
    localparam logic [HALF_W-1:0] HALF_TWO        = 6'h02;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ARM  = 2'b01,
        ST_SYNC = 2'b10,
        ST_CONV = 2'b11
    } sas_state_type;

    typedef enum logic [1:0] {
        KIND_NORMAL = 2'b00,
        KIND_FIRST  = 2'b01,
        KIND_TRIG   = 2'b10
    } sas_kind_type;

    function automatic logic [HALF_W-1:0] sasEndHalf(input sas_kind_type k);
        case (k)
            KIND_FIRST: sasEndHalf = HALF_END_FIRST;
            KIND_TRIG:  sasEndHalf = HALF_END_TRIG;
            default:    sasEndHalf = HALF_END_NORMAL;
        endcase
    endfunction

    function automatic logic [HALF_W-1:0] sasShHalf(input sas_kind_type k);
        case (k)
            KIND_FIRST: sasShHalf = HALF_SH_FIRST;
            KIND_TRIG:  sasShHalf = HALF_SH_TRIG;
            default:    sasShHalf = HALF_SH_NORMAL;
        endcase
    endfunction

endpackage

// *** src/sas_presc_if.sv ***
`timescale 1ns/1ps
interface sas_presc_if;
    import sas_pkg::*;
    logic             clear;
    logic [DIV_W-1:0] divSel;
    logic             halfTick;
    logic             riseTick;

    modport seq  (output clear, output divSel, input halfTick, input riseTick);
    modport presc(input clear, input divSel, output halfTick, output riseTick);
endinterface

// *** src/sas_prescaler.sv ***
`timescale 1ns/1ps
module sas_prescaler
    import sas_pkg::*;
(
    // Clock and reset
    input wire logic  clk,
    input wire logic  sys_rst,
    // Sequencer side
    sas_presc_if.presc pif
);
    logic [PRE_W-1:0] cnt_q;
    logic             phase_q;
    logic [PRE_W-1:0] mask;

    // Half period is two^sel clocks
    assign mask = ~({PRE_W{1'b1}} << pif.divSel); // RULE24
    assign pif.halfTick = ~pif.clear && ((cnt_q & mask) == mask);
    assign pif.riseTick = pif.halfTick && ~phase_q;

    always_ff @(posedge clk) begin
        if (sys_rst || pif.clear) begin // RULE9
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || pif.clear) begin
            phase_q <= 1'b0;
        end else if (pif.halfTick) begin
            phase_q <= ~phase_q;
        end
    end
endmodule // sas_prescaler

// *** src/sas_sequencer.sv ***
`timescale 1ns/1ps
module sas_sequencer
    import sas_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              sys_rst,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [3:0]        wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Trigger sources and sleep
    input  wire logic [6:0]        trigSrc,
    input  wire logic              cpuHalted,
    input  wire logic              sleepQuietMode,
    // Converter core
    input  wire logic [RES_W-1:0]  sarData,
    output logic                   adcPowered,
    output logic      [CHAN_W-1:0] muxChannel,
    output logic      [REF_W-1:0]  refSelect,
    output logic                   sampleHold,
    output logic                   convActive,
    output logic                   convDoneIrq
);
    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    sas_state_type     state_q;
    sas_kind_type      kind_q;
    logic [HALF_W-1:0] halfIdx_q;
    logic [1:0]        syncCnt_q;
    logic              enable_q, autoEn_q, doneFlag_q, irqEn_q, firstPend_q;
    logic [DIV_W-1:0]  divSel_q;
    logic [TRIG_W-1:0] trigSel_q;
    logic [CHAN_W-1:0] chanReg_q, chanLive_q;
    logic [REF_W-1:0]  refReg_q, refLive_q;
    logic [RES_W-1:0]  result_q;
    logic              trigPrev_q, haltPrev_q, sh_q, ack_q;
    logic [31:0]       rdat_q;

    sas_presc_if pif();

    sas_prescaler u_presc (
        .clk     (clk),
        .sys_rst (sys_rst),
        .pif     (pif)
    );

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    logic wbReq, wrA, wrB, wrSel;
    logic swStart, freeRun, trigLevel, trigEdge, trigAccept, sleepStart;
    logic complete, unlock, syncDone, newEnable;
    logic [7:0] trigVec;

    assign wbReq    = wb_cyc_i && wb_stb_i;
    assign wrA      = wbReq && wb_we_i && ack_q && wb_sel_i[0] && (wb_adr_i == ADDR_CTRL_A);
    assign wrB      = wbReq && wb_we_i && ack_q && wb_sel_i[0] && (wb_adr_i == ADDR_CTRL_B);
    assign wrSel    = wbReq && wb_we_i && ack_q && wb_sel_i[0] && (wb_adr_i == ADDR_INSEL);
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= wbReq && ~ack_q;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdat_q <= RESET_WORD;
        end else if (wbReq && ~ack_q) begin
            rdat_q <= RESET_WORD;
            case (wb_adr_i)
                ADDR_CTRL_A: begin
                    rdat_q[BIT_ENABLE]               <= enable_q;
                    rdat_q[BIT_START]                <= state_q != ST_IDLE; // RULE8
                    rdat_q[BIT_AUTO]                 <= autoEn_q;
                    rdat_q[BIT_DONE]                 <= doneFlag_q;
                    rdat_q[BIT_IRQ_EN]               <= irqEn_q;
                    rdat_q[DIV_LSB +: DIV_W]         <= divSel_q;
                end
                ADDR_CTRL_B: rdat_q[TRIG_LSB +: TRIG_W] <= trigSel_q;
                ADDR_INSEL: begin
                    rdat_q[CHAN_LSB +: CHAN_W]       <= chanReg_q;
                    rdat_q[REF_LSB +: REF_W]         <= refReg_q;
                end
                ADDR_RESULT: rdat_q[RES_W-1:0]       <= result_q;
                default:     rdat_q                  <= RESET_WORD;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    assign newEnable = wrA ? wb_dat_i[BIT_ENABLE] : enable_q;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            enable_q  <= 1'b0;
            autoEn_q  <= 1'b0;
            irqEn_q   <= 1'b0;
            divSel_q  <= '0;
            trigSel_q <= '0;
            chanReg_q <= '0;
            refReg_q  <= '0;
        end else begin
            if (wrA) begin
                enable_q <= wb_dat_i[BIT_ENABLE];
                autoEn_q <= wb_dat_i[BIT_AUTO];
                irqEn_q  <= wb_dat_i[BIT_IRQ_EN];
                divSel_q <= wb_dat_i[DIV_LSB +: DIV_W];
            end
            if (wrB) begin
                trigSel_q <= wb_dat_i[TRIG_LSB +: TRIG_W];
            end
            if (wrSel) begin
                chanReg_q <= wb_dat_i[CHAN_LSB +: CHAN_W];
                refReg_q  <= wb_dat_i[REF_LSB +: REF_W];
            end
        end
    end

    // First conversion after power-up is the long one
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            firstPend_q <= 1'b0;
        end else if (newEnable && ~enable_q) begin
            firstPend_q <= 1'b1; // RULE12
        end else if (state_q == ST_CONV) begin
            firstPend_q <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Start sources
    // ----------------------------------------------------------------
    assign trigVec    = {trigSrc, doneFlag_q};
    assign freeRun    = autoEn_q && (trigSel_q == TRIG_FREE_RUN);
    assign trigLevel  = trigVec[trigSel_q];
    assign trigEdge   = trigLevel && ~trigPrev_q; // RULE6
    // Edges only count while idle; a held level never retriggers
    assign trigAccept = trigEdge && autoEn_q && ~freeRun && enable_q && (state_q == ST_IDLE); // RULE4 RULE5
    assign swStart    = wrA && wb_dat_i[BIT_START] && wb_dat_i[BIT_ENABLE] && (state_q == ST_IDLE); // RULE1 RULE8
    assign sleepStart = cpuHalted && ~haltPrev_q && sleepQuietMode && enable_q && ~autoEn_q
                        && irqEn_q && (state_q == ST_IDLE) && ~wrA; // RULE22
    assign syncDone   = (state_q == ST_SYNC) && (syncCnt_q == SYNC_CYCLES - 2'h1);
    assign complete   = (state_q == ST_CONV) && pif.halfTick && (halfIdx_q == sasEndHalf(kind_q) - HALF_ONE);
    assign unlock     = (state_q == ST_CONV) && (halfIdx_q >= sasEndHalf(kind_q) - HALF_TWO);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trigPrev_q <= 1'b0;
            haltPrev_q <= 1'b0;
        end else begin
            trigPrev_q <= trigLevel;
            haltPrev_q <= cpuHalted;
        end
    end

    // Prescaler held in reset while off, restarted by a trigger
    assign pif.clear  = ~enable_q || syncDone; // RULE9 RULE4
    assign pif.divSel = divSel_q;

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst || ~newEnable) begin
            state_q   <= ST_IDLE;
            kind_q    <= KIND_NORMAL;
            halfIdx_q <= '0;
            syncCnt_q <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (swStart || sleepStart) begin
                        state_q <= ST_ARM;
                    end else if (trigAccept) begin
                        state_q   <= ST_SYNC; // RULE15
                        syncCnt_q <= '0;
                    end
                end
                ST_ARM: begin
                    if (pif.riseTick) begin
                        state_q   <= ST_CONV; // RULE11
                        kind_q    <= firstPend_q ? KIND_FIRST : KIND_NORMAL;
                        halfIdx_q <= '0;
                    end
                end
                ST_SYNC: begin
                    syncCnt_q <= syncCnt_q + 2'h1;
                    if (syncDone) begin
                        state_q   <= ST_CONV;
                        kind_q    <= firstPend_q ? KIND_FIRST : KIND_TRIG;
                        halfIdx_q <= '0;
                    end
                end
                ST_CONV: begin
                    if (complete) begin
                        halfIdx_q <= '0;
                        kind_q    <= KIND_NORMAL;
                        // Own flag as source keeps converting, cleared or not
                        state_q   <= freeRun ? ST_CONV : ST_IDLE; // RULE2 RULE7 RULE14 RULE16
                    end else if (pif.halfTick) begin
                        halfIdx_q <= halfIdx_q + HALF_ONE; // RULE12
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Sample-and-hold strobe to the core
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sh_q <= 1'b0;
        end else begin
            sh_q <= (state_q == ST_CONV) && pif.halfTick
                    && (halfIdx_q == sasShHalf(kind_q) - HALF_ONE); // RULE13 RULE15
        end
    end

    // Result and completion flag; a set beats a software clear
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            result_q   <= '0;
            doneFlag_q <= 1'b0;
        end else begin
            if (complete) begin
                result_q   <= sarData; // RULE14
                doneFlag_q <= 1'b1;
            end else if (wrA && wb_dat_i[BIT_DONE]) begin
                doneFlag_q <= 1'b0;
            end
        end
    end

    // Selection buffer: follows software while enabled, except while locked
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            chanLive_q <= '0;
            refLive_q  <= '0;
        end else if (enable_q && (state_q != ST_CONV || unlock)) begin // RULE3 RULE17 RULE20 RULE23
            chanLive_q <= chanReg_q;
            refLive_q  <= refReg_q;
        end
    end

    assign adcPowered  = enable_q; // RULE23
    assign muxChannel  = chanLive_q;
    assign refSelect   = refLive_q;
    assign sampleHold  = sh_q;
    assign convActive  = state_q == ST_CONV;
    assign convDoneIrq = doneFlag_q && irqEn_q; // RULE22

    // ----------------------------------------------------------------
    // Check helpers
    // ----------------------------------------------------------------
    logic [HALF_W-1:0] tally_q;

    // Half periods seen in this conversion, kept apart from the sequencer
    always_ff @(posedge clk) begin
        if (sys_rst || state_q != ST_CONV || complete) begin
            tally_q <= '0;
        end else if (pif.halfTick) begin
            tally_q <= tally_q + HALF_ONE;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence seqSyncRun;
        state_q == ST_SYNC [*3];
    endsequence
    sequence seqConvEntry;
        state_q == ST_CONV && halfIdx_q == '0;
    endsequence

    AST_START_ARMS: assert property (@(posedge clk) disable iff (sys_rst) // RULE1
        swStart |=> state_q == ST_ARM)
        else $error("Software start did not arm the sequencer");
    AST_ARM_RISE: assert property (@(posedge clk) disable iff (sys_rst) // RULE11
        (state_q == ST_ARM && pif.riseTick && newEnable) |=> seqConvEntry)
        else $error("Conversion did not begin on converter rising edge");
    AST_TRIG_SYNC: assert property (@(posedge clk) disable iff (sys_rst) // RULE15
        (trigAccept && ~wrA) |=> seqSyncRun ##1 seqConvEntry)
        else $error("Triggered start did not take three sync cycles");
    AST_NO_RETRIG: assert property (@(posedge clk) disable iff (sys_rst) // RULE5
        (state_q == ST_CONV && trigEdge) |=> state_q != ST_SYNC)
        else $error("Edge during conversion was not ignored");
    AST_DONE_SINGLE: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
        (complete && ~freeRun && ~wrA) |=> state_q == ST_IDLE && doneFlag_q && result_q == $past(sarData))
        else $error("Completion did not store result and clear start");
    AST_FREE_RUN: assert property (@(posedge clk) disable iff (sys_rst) // RULE16
        (complete && freeRun && ~wrA) |=> seqConvEntry and (kind_q == KIND_NORMAL))
        else $error("Free running did not restart immediately");
    AST_END_COUNT: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
        complete |-> (kind_q != KIND_FIRST || halfIdx_q == HALF_END_FIRST - HALF_ONE))
        else $error("First conversion length wrong");
    AST_SH_TIME: assert property (@(posedge clk) disable iff (sys_rst) // RULE13
        sh_q |-> $past(halfIdx_q) == sasShHalf($past(kind_q)) - HALF_ONE)
        else $error("Sample-and-hold at wrong half cycle");
    AST_SEL_LOCK: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
        (state_q == ST_CONV && ~unlock && $past(state_q) == ST_CONV) |-> $stable(chanLive_q))
        else $error("Channel changed during locked conversion");
    AST_PRESC_HELD: assert property (@(posedge clk) disable iff (sys_rst) // RULE9
        ~enable_q |-> ~pif.halfTick)
        else $error("Prescaler ran while converter disabled");
    AST_FLAG_SET_WINS: assert property (@(posedge clk) disable iff (sys_rst) // RULE14
        complete |=> doneFlag_q)
        else $error("Completion flag lost against a clear");
    AST_END_TALLY: assert property (@(posedge clk) disable iff (sys_rst) // RULE12
        complete |-> tally_q == sasEndHalf(kind_q) - HALF_ONE)
        else $error("Conversion ended after wrong number of half periods");
    AST_OFF_IDLE: assert property (@(posedge clk) disable iff (sys_rst) // RULE23
        ~enable_q |-> state_q == ST_IDLE)
        else $error("Sequencer active while converter disabled");
    AST_SLEEP_ARMS: assert property (@(posedge clk) disable iff (sys_rst) // RULE22
        sleepStart |=> state_q == ST_ARM)
        else $error("Sleep entry did not arm a conversion");
    AST_IRQ_WAKE: assert property (@(posedge clk) disable iff (sys_rst) // RULE22
        (complete && irqEn_q && ~wrA) |=> convDoneIrq)
        else $error("Completion did not raise the wake request");
    AST_SEL_FOLLOW: assert property (@(posedge clk) disable iff (sys_rst) // RULE17
        (enable_q && state_q == ST_IDLE) |=> chanLive_q == $past(chanReg_q) && refLive_q == $past(refReg_q))
        else $error("Selection buffer did not follow while idle");
    AST_START_READS: assert property (@(posedge clk) disable iff (sys_rst) // RULE8
        (wbReq && ~ack_q && wb_adr_i == ADDR_CTRL_A && state_q != ST_IDLE) |=> wb_dat_o[BIT_START])
        else $error("Start bit did not read one during conversion");
endmodule // sas_sequencer
